// *** common/sbdt_cfg.svh ***
// Register map, field positions, reset values and timing counts
// Assumes 32-bit APB data and a 100 MHz pclk
`ifndef SBDT_CFG_SVH
`define SBDT_CFG_SVH
`define SBDT_CLK_MHZ 100
`define SBDT_TMO_NS 1000
`define SBDT_TMO_CYC ((`SBDT_TMO_NS * `SBDT_CLK_MHZ) / 1000)
`define SBDT_A_CTRL 8'h00
`define SBDT_A_THR 8'h04
`define SBDT_A_HYS 8'h08
`define SBDT_A_TMO 8'h0c
`define SBDT_A_PMIN 8'h10
`define SBDT_A_PMAX 8'h14
`define SBDT_A_TRIG 8'h18
`define SBDT_A_FILT 8'h1c
`define SBDT_A_STAT 8'h20
`define SBDT_A_FCNT 8'h24
`define SBDT_A_FSTART 8'h28
`define SBDT_A_FBIT 8'h2c
`define SBDT_A_WMOSI 8'h30
`define SBDT_A_WMISO 8'h34
`define SBDT_C_EN 0
`define SBDT_C_LSB 1
`define SBDT_C_CPOL 2
`define SBDT_C_CPHA 3
`define SBDT_C_PMOSI 4
`define SBDT_C_PMISO 5
`define SBDT_C_PCS 6
`define SBDT_C_FTMO 7
`define SBDT_C_MOSIA 8
`define SBDT_C_MISOA 9
`define SBDT_C_TT 11:10
`define SBDT_C_WALGN 12
`define SBDT_C_WLEN 20:16
`define SBDT_CTRL_RST 32'h0007_0340
`define SBDT_THR_RST 32'h8080_8080
`define SBDT_F_IMIN 19:8
`define SBDT_F_IMAX 31:20
`define SBDT_F_ERR 6:4
`define SBDT_T_POS 31:16
`endif

// *** common/sbdt_pkg.sv ***
// Types shared by the link monitor
// Assumes the constants header supplies all numbers
package sbdt_pkg;
  typedef enum logic [1:0] {
    FS_OK = 2'h0, FS_VOID = 2'h1, FS_LEN = 2'h2, FS_INC = 2'h3
  } sbdt_fst_t;
  typedef enum logic [2:0] {
    OP_EQ = 3'h0, OP_NE = 3'h1, OP_LT = 3'h2, OP_LE = 3'h3,
    OP_GT = 3'h4, OP_GE = 3'h5, OP_IN = 3'h6, OP_OUT = 3'h7
  } sbdt_op_t;
  typedef enum logic [1:0] {
    TT_SOF = 2'h0, TT_EOF = 2'h1, TT_MOSI = 2'h2, TT_MISO = 2'h3
  } sbdt_tt_t;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_FRM = 2'b10} sbdt_fsm_t;
  typedef struct packed {
    logic [31:0] mosi;
    logic [31:0] miso;
    logic [15:0] idx;
    logic sel;
  } sbdt_word_t;
  typedef struct packed {
    logic [15:0] idx;
    sbdt_fst_t st;
    logic pass;
    logic [31:0] start;
    logic [15:0] cnt;
    logic [31:0] bitper;
  } sbdt_frame_t;
endpackage : sbdt_pkg

// *** src/sbdt_top.sv ***
// Passive monitor of a four-wire serial peripheral link
// Assumes sampled line values arrive unsynchronised; APB on pclk
`timescale 1ns/1ps
`default_nettype none
`include "sbdt_cfg.svh"
module sbdt_top #(
  parameter int SMPW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0][SMPW-1:0] line_smp,
  output sbdt_pkg::sbdt_word_t word_o,
  output logic word_stb,
  output sbdt_pkg::sbdt_frame_t frame_o,
  output logic frame_stb,
  output logic trig,
  output logic in_frame
);
  logic [31:0] ctrl_r, thr_r, hys_r, tmo_r, pmin_r, pmax_r, trg_r, filt_r;
  logic [31:0] rdata_r, ts_r, per_cnt_r, per_r;
  logic err_r, word_stb_r, frame_stb_r, trig_r, cs_d_r, sclk_d_r;
  logic [3:0][SMPW-1:0] s1_r, s2_r;
  logic [3:0] lvl_r;
  logic [31:0] mo_sh_r, mi_sh_r, mo_nxt, mi_nxt, mo_val, mi_val;
  logic [5:0] bcnt_r;
  logic [15:0] wcnt_r, btot_r, fidx_r;
  logic [31:0] idle_r, fstart_r;
  sbdt_pkg::sbdt_fsm_t st_r;
  sbdt_pkg::sbdt_word_t word_r;
  sbdt_pkg::sbdt_frame_t frame_r;
  sbdt_pkg::sbdt_fst_t fst;
  sbdt_pkg::sbdt_tt_t tt;
  logic en, lsb, ftmo, walgn, cs_act, mo_bit, mi_bit, rise, fall;
  logic smp_edge, open_f, close_f, cap, word_done, pat_pos, pat_hit;
  logic wr, rd_set, mapped;
  logic [4:0] wm1;
  logic [2:0] err_en;
  logic [15:0] pos;

  function automatic logic [31:0] ord(input logic [31:0] v,
    input logic lf, input logic [4:0] m);
    logic [31:0] r;
    r = '0;
    for (int k = 0; k < 32; k++) begin
      r[k] = v[31-k];
    end
    if (lf) begin
      ord = r >> (5'd31 - m);
    end else begin
      ord = v & (32'hffff_ffff >> (5'd31 - m));
    end
  endfunction : ord

  function automatic logic cmp(input logic [2:0] op,
    input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    unique case (sbdt_pkg::sbdt_op_t'(op))
      sbdt_pkg::OP_EQ: cmp = (a == lo);
      sbdt_pkg::OP_NE: cmp = (a != lo);
      sbdt_pkg::OP_LT: cmp = (a < lo);
      sbdt_pkg::OP_LE: cmp = (a <= lo);
      sbdt_pkg::OP_GT: cmp = (a > lo);
      sbdt_pkg::OP_GE: cmp = (a >= lo);
      sbdt_pkg::OP_IN: cmp = (a >= lo) && (a <= hi);
      sbdt_pkg::OP_OUT: cmp = (a < lo) || (a > hi);
    endcase
  endfunction : cmp

  assign en = ctrl_r[`SBDT_C_EN];
  assign lsb = ctrl_r[`SBDT_C_LSB];
  assign ftmo = ctrl_r[`SBDT_C_FTMO];
  assign walgn = ctrl_r[`SBDT_C_WALGN];
  assign wm1 = ctrl_r[`SBDT_C_WLEN];
  assign tt = sbdt_pkg::sbdt_tt_t'(ctrl_r[`SBDT_C_TT]);
  assign pos = trg_r[`SBDT_T_POS];
  assign err_en = filt_r[`SBDT_F_ERR];

  // Two-stage sync, then threshold with hysteresis per line
  for (genvar i = 0; i < 4; i++) begin : g_line
    logic [SMPW:0] hi_th;
    logic [SMPW-1:0] lo_th;
    assign hi_th = {1'b0, thr_r[8*i+:SMPW]} + {1'b0, hys_r[8*i+:SMPW]};
    assign lo_th = (thr_r[8*i+:SMPW] > hys_r[8*i+:SMPW]) ?
      thr_r[8*i+:SMPW] - hys_r[8*i+:SMPW] : '0;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1_r[i] <= '0;
        s2_r[i] <= '0;
        lvl_r[i] <= 1'b0;
      end else begin
        s1_r[i] <= line_smp[i];
        s2_r[i] <= s1_r[i];
        if (!lvl_r[i] && ({1'b0, s2_r[i]} > hi_th)) begin
          lvl_r[i] <= 1'b1;
        end else if (lvl_r[i] && (s2_r[i] <= lo_th)) begin
          lvl_r[i] <= 1'b0;
        end
      end
    end
    lvl_hi_a: assert property (@(posedge pclk) disable iff (!presetn)
      !lvl_r[i] && ({1'b0, s2_r[i]} > hi_th) |=> lvl_r[i])
      else $error("Line not high above threshold");
  end

  // Line 0 clock, 1 main-out, 2 main-in, 3 select
  assign mo_bit = lvl_r[1] ^ ctrl_r[`SBDT_C_PMOSI];
  assign mi_bit = lvl_r[2] ^ ctrl_r[`SBDT_C_PMISO];
  assign cs_act = lvl_r[3] ^ ctrl_r[`SBDT_C_PCS];
  assign rise = lvl_r[0] & ~sclk_d_r;
  assign fall = ~lvl_r[0] & sclk_d_r;
  // Modes 0 and 3 sample rising, 1 and 2 falling
  assign smp_edge = (ctrl_r[`SBDT_C_CPOL] ^ ctrl_r[`SBDT_C_CPHA]) ?
    fall : rise;

  assign open_f = en && (st_r == sbdt_pkg::ST_IDLE) &&
    (ftmo ? smp_edge : (cs_act && !cs_d_r));
  assign close_f = (st_r == sbdt_pkg::ST_FRM) && (!en ||
    (ftmo ? (idle_r >= tmo_r) : !cs_act));
  assign cap = smp_edge && en && !close_f &&
    ((st_r == sbdt_pkg::ST_FRM) || open_f);
  assign word_done = cap && (bcnt_r[4:0] == wm1);
  assign mo_nxt = {mo_sh_r[30:0], mo_bit};
  assign mi_nxt = {mi_sh_r[30:0], mi_bit};
  assign mo_val = ord(mo_nxt, lsb, wm1);
  assign mi_val = ord(mi_nxt, lsb, wm1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b0;
      ts_r <= '0;
    end else begin
      sclk_d_r <= lvl_r[0];
      cs_d_r <= cs_act;
      ts_r <= ts_r + 32'h1;
    end
  end

  // Clock idle time, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_r <= '0;
    end else if (rise || fall) begin
      idle_r <= '0;
    end else if (idle_r != 32'hffff_ffff) begin
      idle_r <= idle_r + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= sbdt_pkg::ST_IDLE;
    end else begin
      unique case (st_r)
        sbdt_pkg::ST_IDLE: if (open_f) st_r <= sbdt_pkg::ST_FRM;
        sbdt_pkg::ST_FRM: if (close_f) st_r <= sbdt_pkg::ST_IDLE;
        default: st_r <= sbdt_pkg::ST_IDLE;
      endcase
    end
  end
  assign in_frame = (st_r == sbdt_pkg::ST_FRM);

  // Bit shifting and word counting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mo_sh_r <= '0;
      mi_sh_r <= '0;
      bcnt_r <= '0;
      wcnt_r <= '0;
      btot_r <= '0;
    end else begin
      if (open_f) begin
        bcnt_r <= '0;
        wcnt_r <= '0;
        btot_r <= '0;
      end
      if (cap) begin
        mo_sh_r <= mo_nxt;
        mi_sh_r <= mi_nxt;
        btot_r <= (open_f ? 16'h0 : btot_r) + 16'h1;
        bcnt_r <= word_done ? 6'h0 : (open_f ? 6'h0 : bcnt_r) + 6'h1;
      end
      if (word_done) begin
        wcnt_r <= (open_f ? 16'h0 : wcnt_r) + 16'h1;
      end
    end
  end

  word_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    cap && !open_f && (bcnt_r[4:0] == wm1) |=> word_stb_r && (bcnt_r == 6'h0))
    else $error("Word not closed at configured length");

  // Word report with index filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_r <= '0;
      word_stb_r <= 1'b0;
    end else begin
      word_stb_r <= word_done;
      if (word_done) begin
        word_r.mosi <= mo_val;
        word_r.miso <= mi_val;
        word_r.idx <= open_f ? 16'h0 : wcnt_r;
        word_r.sel <= cmp(filt_r[2:0], {16'h0, open_f ? 16'h0 : wcnt_r},
          {20'h0, filt_r[`SBDT_F_IMIN]},
          {20'h0, filt_r[`SBDT_F_IMAX]});
      end
    end
  end
  assign word_o = word_r;
  assign word_stb = word_stb_r;

  // Pattern search on the assigned data line
  assign pat_pos = walgn ?
    (word_done && ((open_f ? 16'h0 : wcnt_r) >= pos)) :
    (cap && ({1'b0, open_f ? 16'h0 : btot_r} >=
      {1'b0, pos} + {12'h0, wm1}));
  assign pat_hit = pat_pos && (
    (tt == sbdt_pkg::TT_MOSI && ctrl_r[`SBDT_C_MOSIA] &&
      cmp(trg_r[2:0], mo_val, pmin_r, pmax_r)) ||
    (tt == sbdt_pkg::TT_MISO && ctrl_r[`SBDT_C_MISOA] &&
      cmp(trg_r[2:0], mi_val, pmin_r, pmax_r)));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= (tt == sbdt_pkg::TT_SOF && open_f) ||
        (tt == sbdt_pkg::TT_EOF && close_f) || pat_hit;
    end
  end
  assign trig = trig_r;

  sof_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
    open_f && tt == sbdt_pkg::TT_SOF |=> trig_r ##1 !trig_r [*1])
    else $error("No start trigger");
  eof_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
    close_f && tt == sbdt_pkg::TT_EOF |=> trig_r && frame_stb_r)
    else $error("No end trigger with frame report");
  cs_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    en && !ftmo && st_r == sbdt_pkg::ST_IDLE && cs_act && !cs_d_r
    |=> in_frame)
    else $error("Select did not open frame");
  tmo_close_a: assert property (@(posedge pclk) disable iff (!presetn)
    in_frame && ftmo && idle_r >= tmo_r |=> !in_frame && frame_stb_r)
    else $error("Idle timeout did not close frame");

  // Bit period between sampling slopes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      per_cnt_r <= '0;
      per_r <= '0;
    end else if (cap) begin
      per_cnt_r <= 32'h1;
      if (!open_f && btot_r != 16'h0) per_r <= per_cnt_r;
    end else begin
      per_cnt_r <= per_cnt_r + 32'h1;
    end
  end

  // Frame close report and error class
  always_comb begin
    if (!en) fst = sbdt_pkg::FS_INC;
    else if (wcnt_r == 16'h0) fst = sbdt_pkg::FS_VOID;
    else if (bcnt_r != 6'h0) fst = sbdt_pkg::FS_LEN;
    else fst = sbdt_pkg::FS_OK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_r <= '0;
      frame_stb_r <= 1'b0;
      fidx_r <= '0;
      fstart_r <= '0;
    end else begin
      frame_stb_r <= close_f;
      if (open_f) fstart_r <= ts_r;
      if (close_f) begin
        fidx_r <= fidx_r + 16'h1;
        frame_r.idx <= fidx_r;
        frame_r.st <= fst;
        frame_r.pass <= (fst == sbdt_pkg::FS_OK) ||
          err_en[fst - 2'h1];
        frame_r.start <= fstart_r;
        frame_r.cnt <= wcnt_r;
        frame_r.bitper <= per_r;
      end
    end
  end
  assign frame_o = frame_r;
  assign frame_stb = frame_stb_r;

  void_a: assert property (@(posedge pclk) disable iff (!presetn)
    close_f && en && wcnt_r == 16'h0 |=> frame_o.st == sbdt_pkg::FS_VOID)
    else $error("Empty frame not void");
  len_a: assert property (@(posedge pclk) disable iff (!presetn)
    close_f && en && wcnt_r != 16'h0 && bcnt_r != 6'h0
    |=> frame_o.st == sbdt_pkg::FS_LEN && frame_o.cnt == $past(wcnt_r))
    else $error("Partial word not a length error");

  // APB slave: read data captured in setup, zero wait states
  assign wr = psel && penable && pwrite;
  assign rd_set = psel && !penable;
  always_comb begin
    mapped = (paddr <= `SBDT_A_WMISO) && (paddr[1:0] == 2'h0);
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_r;
  assign prdata = rdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= '0;
      err_r <= 1'b0;
    end else if (rd_set) begin
      err_r <= !mapped;
      unique case (paddr)
        `SBDT_A_CTRL: rdata_r <= ctrl_r;
        `SBDT_A_THR: rdata_r <= thr_r;
        `SBDT_A_HYS: rdata_r <= hys_r;
        `SBDT_A_TMO: rdata_r <= tmo_r;
        `SBDT_A_PMIN: rdata_r <= pmin_r;
        `SBDT_A_PMAX: rdata_r <= pmax_r;
        `SBDT_A_TRIG: rdata_r <= trg_r;
        `SBDT_A_FILT: rdata_r <= filt_r;
        `SBDT_A_STAT: rdata_r <= {28'h0, frame_r.pass, frame_r.st, in_frame};
        `SBDT_A_FCNT: rdata_r <= {frame_r.idx, frame_r.cnt};
        `SBDT_A_FSTART: rdata_r <= frame_r.start;
        `SBDT_A_FBIT: rdata_r <= frame_r.bitper;
        `SBDT_A_WMOSI: rdata_r <= word_r.mosi;
        `SBDT_A_WMISO: rdata_r <= word_r.miso;
        default: rdata_r <= '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `SBDT_CTRL_RST;
      thr_r <= `SBDT_THR_RST;
      hys_r <= '0;
      tmo_r <= `SBDT_TMO_CYC;
      pmin_r <= '0;
      pmax_r <= '0;
      trg_r <= '0;
      filt_r <= '0;
    end else if (wr) begin
      unique case (paddr)
        `SBDT_A_CTRL: ctrl_r <= pwdata;
        `SBDT_A_THR: thr_r <= pwdata;
        `SBDT_A_HYS: hys_r <= pwdata;
        `SBDT_A_TMO: tmo_r <= pwdata;
        `SBDT_A_PMIN: pmin_r <= pwdata;
        `SBDT_A_PMAX: pmax_r <= pwdata;
        `SBDT_A_TRIG: trg_r <= pwdata;
        `SBDT_A_FILT: filt_r <= pwdata;
        default: ;
      endcase
    end
  end
endmodule : sbdt_top
`default_nettype wire

// *** test/sbdt_spi_model.sv ***
// Far-end model: a main and a sub driving clock, select and both data lines
// Assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
`default_nettype none
module sbdt_spi_model (
  output logic [3:0][7:0] line_smp
);
  localparam logic [7:0] HI = 8'hd0;
  localparam logic [7:0] LO = 8'h30;
  logic cpol = 1'b0;
  logic cpha = 1'b0;
  logic cs_act = 1'b0;
  initial line_smp = {HI, LO, HI, LO};
  function automatic logic [7:0] lv(input logic b);
    return b ? HI : LO;
  endfunction : lv
  // Clock mode shared by both ends of the link
  task automatic cfg(input logic pol, input logic pha, input logic act);
    cpol = pol;
    cpha = pha;
    cs_act = act;
    line_smp[0] = lv(pol);
    line_smp[3] = lv(!act);
  endtask : cfg
  task automatic open_frm(input logic use_cs);
    #3.7;
    if (use_cs) line_smp[3] = lv(cs_act);
    #62.5;
  endtask : open_frm
  // Data launched on the edge opposite the sampling one
  task automatic bit_out(input logic mo, input logic mi);
    if (cpha) line_smp[0] = lv(!cpol);
    line_smp[1] = lv(mo); // Both lines move in one bit period
    line_smp[2] = lv(mi);
    #62.5;
    line_smp[0] = lv(cpha ? cpol : !cpol);
    #62.5;
    if (!cpha) line_smp[0] = lv(cpol);
  endtask : bit_out
  // Released data lines show the inverse of their last level
  task automatic close_frm(input logic use_cs);
    #62.5;
    if (use_cs) line_smp[3] = lv(!cs_act);
    line_smp[1] = lv(line_smp[1] != HI);
    line_smp[2] = lv(line_smp[2] != HI);
    #62.5;
  endtask : close_frm
endmodule : sbdt_spi_model
`default_nettype wire

// *** test/sbdt_top_tb_top.sv ***
// Bench for the link monitor: APB setup, far-end traffic, self-checks
// Assumes the far-end model drives the sampled line values
`timescale 1ns/1ps
`default_nettype none
`include "sbdt_cfg.svh"
module sbdt_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0][7:0] line_smp;
  sbdt_pkg::sbdt_word_t word_o;
  logic word_stb;
  sbdt_pkg::sbdt_frame_t frame_o;
  logic frame_stb;
  logic trig;
  logic in_frame;
  int mismatches = 0;
  int comparisons = 0;
  int trig_n = 0;
  sbdt_pkg::sbdt_word_t wq[$];
  sbdt_pkg::sbdt_frame_t fq[$];
  logic [31:0] rd;
  logic er;
  logic [31:0] mo[4];
  logic [31:0] mi[4];
  logic [31:0] xmk = 32'hffff_ffff;
  logic cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, pmo = 1'b0, pcs = 1'b1;
  logic ftmo = 1'b0, walgn = 1'b1, asg = 1'b1, fseen = 1'b0;
  logic [1:0] tt = 2'h0;
  int wl = 8;
  logic [15:0] lidx;
  logic [31:0] lst;
  sbdt_top #(.SMPW(8)) dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .line_smp(line_smp), .word_o(word_o), .word_stb(word_stb),
    .frame_o(frame_o), .frame_stb(frame_stb), .trig(trig), .in_frame(in_frame));
  sbdt_spi_model sm_u (.line_smp(line_smp));
  initial forever #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (word_stb === 1'b1) wq.push_back(word_o);
    if (frame_stb === 1'b1) fq.push_back(frame_o);
    if (trig === 1'b1) trig_n++;
  end
  task automatic stop_test();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(pready, 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [31:0] ctl();
    return {11'h0, 5'(wl - 1), 3'h0, walgn, tt, 1'b1, asg, ftmo, pcs, 1'b0, pmo, cpha, cpol,
      lsb, 1'b1};
  endfunction : ctl
  function automatic logic expop(input logic [2:0] op, input logic [31:0] a,
      input logic [31:0] lo, input logic [31:0] hi);
    case (op)
      3'h0: return a == lo;
      3'h1: return a != lo;
      3'h2: return a < lo;
      3'h3: return a <= lo;
      3'h4: return a > lo;
      3'h5: return a >= lo;
      3'h6: return a >= lo && a <= hi;
      default: return a < lo || a > hi;
    endcase
  endfunction : expop
  task automatic setc();
    apb(1'b1, `SBDT_A_CTRL, ctl() & ~32'h1);
    sm_u.cfg(cpol, cpha, !pcs);
    repeat (4) @(posedge pclk);
    apb(1'b1, `SBDT_A_CTRL, ctl());
  endtask : setc
  task automatic wfrm();
    int n;
    n = 0;
    while (fq.size() == 0 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    repeat (2) @(posedge pclk);
    chk(fq.size(), 1);
  endtask : wfrm
  task automatic send(input int nw, input int xb, input sbdt_pkg::sbdt_fst_t st);
    int n;
    logic [31:0] mk;
    sbdt_pkg::sbdt_frame_t f;
    mk = (wl == 32) ? 32'hffff_ffff : (32'h1 << wl) - 32'h1;
    wq.delete();
    fq.delete();
    trig_n = 0;
    sm_u.open_frm(!ftmo);
    for (int w = 0; w < nw; w++) begin
      for (int i = 0; i < wl; i++) begin
        n = lsb ? i : wl - 1 - i;
        sm_u.bit_out(mo[w][n] ^ pmo, mi[w][n]);
      end
    end
    for (int i = 0; i < xb; i++) sm_u.bit_out(1'b1, 1'b0);
    if (!ftmo) chk(in_frame, 1'b1);
    sm_u.close_frm(!ftmo);
    wfrm();
    if (fq.size() > 0) begin
      f = fq[0];
      chk(f.st, st);
      chk(f.pass, st == sbdt_pkg::FS_OK || st == sbdt_pkg::FS_LEN);
      chk(f.cnt, nw);
      if (fseen) chk(f.idx, lidx + 16'h1);
      if (fseen) chk(f.start > lst, 1'b1);
      if (nw > 0) chk(f.bitper == 32'd12 || f.bitper == 32'd13, 1'b1);
      lidx = f.idx;
      lst = f.start;
      fseen = 1'b1;
    end
    chk(wq.size(), nw);
    for (int w = 0; w < nw && w < wq.size(); w++) begin
      if (asg) chk(wq[w].mosi & mk, mo[w] & mk & xmk);
      chk(wq[w].miso & mk, mi[w] & mk);
      chk(wq[w].idx, w);
      chk(wq[w].sel, expop(3'h6, w, 32'h1, 32'h2));
    end
    chk(in_frame, 1'b0);
  endtask : send
  initial begin
    #800_000;
    mismatches++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h7346));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SBDT_A_CTRL, 32'h0);
    chk(rd, 32'h0007_0340);
    apb(1'b0, `SBDT_A_THR, 32'h0);
    chk(rd, 32'h8080_8080);
    apb(1'b0, 8'h38, 32'h0);
    chk(er, 1'b1);
    apb(1'b1, `SBDT_A_HYS, 32'h0);
    apb(1'b1, `SBDT_A_TMO, 32'd20);
    apb(1'b1, `SBDT_A_FILT, 32'h0020_0126);
    for (int k = 0; k < 8; k++) begin
      {cpol, cpha, lsb} = 3'($urandom);
      wl = (k == 0) ? 32 : $urandom_range(32, 1);
      for (int w = 0; w < 4; w++) begin
        mo[w] = $urandom;
        mi[w] = $urandom;
      end
      setc();
      send($urandom_range(3, 1), 0, sbdt_pkg::FS_OK);
      chk(trig_n, 1);
    end
    {cpol, cpha, lsb, wl, tt, pmo, pcs} = {3'b000, 32'd8, 2'h1, 2'b10};
    setc();
    send(2, 0, sbdt_pkg::FS_OK);
    chk(trig_n, 1);
    {pmo, pcs} = 2'b01;
    setc();
    send(1, 4, sbdt_pkg::FS_LEN);
    send(0, 0, sbdt_pkg::FS_VOID);
    apb(1'b1, `SBDT_A_THR, 32'h8080_d880);
    xmk = 32'h0;
    send(1, 0, sbdt_pkg::FS_OK);
    apb(1'b1, `SBDT_A_THR, 32'h8080_8080);
    xmk = 32'hffff_ffff;
    apb(1'b1, `SBDT_A_PMIN, 32'h40);
    apb(1'b1, `SBDT_A_PMAX, 32'h50);
    for (int k = 0; k < 16; k++) begin
      tt = 2'h2 + 2'(k / 8);
      setc();
      apb(1'b1, `SBDT_A_TRIG, 32'(k % 8));
      mo[0] = tt[0] ? 32'hbf : 32'h40;
      mi[0] = tt[0] ? 32'h40 : 32'hbf;
      send(1, 0, sbdt_pkg::FS_OK);
      chk(trig_n, expop(3'(k), 32'h40, 32'h40, 32'h50));
    end
    {tt, mo[0], mo[1]} = {2'h2, 32'h05, 32'ha3};
    apb(1'b1, `SBDT_A_PMIN, 32'h5a);
    apb(1'b1, `SBDT_A_TRIG, 32'h0);
    setc();
    send(2, 0, sbdt_pkg::FS_OK);
    chk(trig_n, 0);
    walgn = 1'b0;
    setc();
    send(2, 0, sbdt_pkg::FS_OK);
    chk(trig_n, 1);
    {walgn, mo[0], mo[1]} = {1'b1, 32'h5a, 32'h5a};
    apb(1'b1, `SBDT_A_TRIG, 32'h0001_0000);
    setc();
    send(2, 0, sbdt_pkg::FS_OK);
    chk(trig_n, 1);
    asg = 1'b0;
    setc();
    send(2, 0, sbdt_pkg::FS_OK);
    chk(trig_n, 0);
    {asg, tt} = {1'b1, 2'h0};
    setc();
    fq.delete();
    sm_u.open_frm(1'b1);
    repeat (4) sm_u.bit_out(1'b1, 1'b0);
    apb(1'b1, `SBDT_A_CTRL, ctl() & ~32'h1);
    wfrm();
    chk(fq.size() > 0 ? fq[0].st : sbdt_pkg::FS_OK, sbdt_pkg::FS_INC);
    sm_u.close_frm(1'b1);
    {ftmo, tt, fseen} = {1'b1, 2'h1, 1'b0};
    setc();
    send(2, 0, sbdt_pkg::FS_OK);
    chk(trig_n, 1);
    stop_test();
  end
endmodule : sbdt_top_tb_top
`default_nettype wire
